// File: rtl/csd_pkg.sv
package csd_pkg;
    localparam int CSD_W       = 4;
    localparam int SHIFT_W     = 3;
    localparam int SIGN_POS    = 3;
    localparam int TERMS_MAX   = 4;
    localparam int FIR_TERMS   = 3;
    localparam int B_TAPS      = 8;
    localparam int COEF_W      = 16;
    localparam int FRAC_BITS   = 12;
    localparam int CTRL_LINES  = 5;
    localparam int CH_CNT      = 2;
    localparam int CLK_HZ      = 20000000;
    localparam int CHOP_HZ     = 256000;
    localparam int CHOP_HALF   = CLK_HZ / (2 * CHOP_HZ);
    localparam logic [7:0] CMD_SET_IMP   = 8'h0D;
    localparam logic [7:0] CMD_CTL_WR    = 8'h0F;
    localparam logic [7:0] CMD_CTL_RD    = 8'h10;
    localparam logic [7:0] CMD_DIR_WR    = 8'h11;
    localparam logic [7:0] CMD_ADAPT     = 8'h13;
    localparam logic [7:0] CMD_LOOP      = 8'h15;
    localparam logic [7:0] CMD_BAL_WR    = 8'h1E;
    localparam logic [7:0] CMD_BAL_RD    = 8'h1F;
    localparam logic [7:0] CMD_EPG_WR    = 8'h24;
    localparam logic [7:0] CMD_ELT_WR    = 8'h26;
    localparam logic [7:0] CMD_TEST      = 8'h27;
    localparam logic [4:0] IMP_LOOPBACK  = 5'h10;
    localparam int TEST_HPF_BYP = 0;
    localparam int TEST_RX_CUT  = 1;
    localparam int TEST_TX_CUT  = 2;
    localparam int TEST_ALOOP   = 3;
    localparam logic [COEF_W-1:0] ONE_FIXED =
        COEF_W'(1) << FRAC_BITS;

    // decodes up to n chained terms, each shifting from the previous one
    function automatic logic signed [COEF_W-1:0] csd_decode(
        input logic [4*CSD_W-1:0] terms, input int n);
        logic signed [COEF_W-1:0] acc;
        logic                     neg;
        int                       sh;
        acc = '0;
        neg = 1'b0;
        sh  = 0;
        for (int x = 0; x < TERMS_MAX; x++) begin
            if (x < n) begin
                neg = neg ^ terms[x*CSD_W+SIGN_POS];
                sh  = sh + int'(terms[x*CSD_W +: SHIFT_W]);
                if (neg)
                    acc = acc - COEF_W'(ONE_FIXED >> sh);
                else
                    acc = acc + COEF_W'(ONE_FIXED >> sh);
            end
        end
        return acc;
    endfunction
endpackage

// File: rtl/codec_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface codec_cmd_if;
    logic       cmd_valid;
    logic [7:0] cmd_code;
    logic       wr_valid;
    logic [7:0] wr_data;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       busy;
    modport dev  (input cmd_valid, cmd_code, wr_valid, wr_data,
                  output rd_valid, rd_data, busy);
    modport host (output cmd_valid, cmd_code, wr_valid, wr_data,
                  input rd_valid, rd_data, busy);
endinterface
`default_nettype wire

// File: rtl/csd_filter_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module csd_filter_ctrl
    import csd_pkg::*;
#(
    parameter int NUM_LINES = CTRL_LINES
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    codec_cmd_if.dev                  cmd,
    input  wire logic [CH_CNT-1:0]    chan_active,
    input  wire logic [7:0]           pcm_receive_input,
    input  wire logic signed [COEF_W-1:0] tx_level,
    input  wire logic signed [COEF_W-1:0] rx_level,
    input  wire logic signed [COEF_W-1:0] err_level,
    input  wire logic [NUM_LINES-1:0] line_in,
    output logic [7:0]                pcm_transmit_output,
    output logic                      chopper_clock,
    output logic [NUM_LINES-1:0]      line_out,
    output logic [NUM_LINES-1:0]      line_oe,
    output logic                      conv_loopback,
    output logic                      analog_out_drive,
    output logic                      analog_loopback,
    output logic                      hpf_bypass,
    output logic                      rx_cut,
    output logic                      tx_cut,
    output logic                      adapt_running,
    output logic signed [COEF_W-1:0]  tx_gain_coef
);
    typedef enum {ST_IDLE, ST_WRITE, ST_READ} cmd_state_t;
    cmd_state_t st_q;
    logic [7:0] op_q;
    logic [3:0] idx_q;
    logic [CSD_W-1:0] tap_q [B_TAPS];
    logic [4*CSD_W-1:0] fb_q, epg_q, elt_q, gx_q;
    logic [NUM_LINES-1:0] lat_q, dir_q;
    logic [NUM_LINES-1:0] ls1_q, ls2_q, ls3_q, lin_q;
    logic conv_q;
    logic [3:0] test_q;
    logic loop_q, adapt_q;
    logic [7:0] rd_q, pcm_q;
    logic rv_q;
    logic [$clog2(CHOP_HALF+1)-1:0] chop_cnt_q;
    logic chop_q;
    logic [2:0] tap_sel_q;
    logic signed [COEF_W-1:0] gxc_q;

    wire signed [COEF_W-1:0] epg_val = csd_decode(epg_q, TERMS_MAX);
    wire signed [COEF_W-1:0] elt_val = csd_decode(elt_q, 2);
    wire signed [COEF_W-1:0] gx_val  = csd_decode(gx_q, TERMS_MAX);
    // full-width product; the echo estimate keeps bits 27:12 and drops the top bits
    wire signed [2*COEF_W-1:0] echo_prod = rx_level * epg_val;
    wire signed [COEF_W-1:0] echo_est =
        COEF_W'(echo_prod >>> FRAC_BITS);
    wire near_talk  = tx_level > echo_est;
    wire converged  = err_level <= elt_val;
    wire adapt_step = adapt_q && !near_talk && !converged;
    wire [CSD_W-1:0] cur_tap = tap_q[tap_sel_q];
    wire [SHIFT_W-1:0] cur_sh = cur_tap[SHIFT_W-1:0];
    wire err_pos = err_level > 0;
    wire [CSD_W-1:0] tap_next =
        {err_pos, (cur_sh == '1) ? cur_sh : cur_sh + SHIFT_W'(1)};
    wire wr_ok = cmd.wr_valid && st_q == ST_WRITE;
    wire [3:0] bal_bytes = 4'((B_TAPS*CSD_W) / 8 + 2);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            op_q <= '0;
            idx_q <= '0;
            rd_q <= '0;
            rv_q <= 1'b0;
        end else begin
            rv_q <= 1'b0;
            case (st_q)
                ST_IDLE: if (cmd.cmd_valid) begin
                    op_q  <= cmd.cmd_code;
                    idx_q <= '0;
                    st_q  <= (cmd.cmd_code == CMD_CTL_RD ||
                              cmd.cmd_code == CMD_BAL_RD) ? ST_READ
                             : ST_WRITE;
                end
                ST_WRITE: if (cmd.wr_valid) begin
                    idx_q <= idx_q + 4'(1);
                    if (op_q != CMD_BAL_WR && op_q != CMD_EPG_WR ||
                        op_q == CMD_BAL_WR && idx_q == bal_bytes - 4'(1) ||
                        op_q == CMD_EPG_WR && idx_q == 4'(1))
                        st_q <= ST_IDLE;
                end
                ST_READ: begin
                    rv_q  <= 1'b1;
                    idx_q <= idx_q + 4'(1);
                    if (op_q == CMD_CTL_RD)
                        rd_q <= 8'(lin_q);
                    else if (idx_q < 4'(B_TAPS/2))
                        rd_q <= {tap_q[2*idx_q+1], tap_q[2*idx_q]};
                    else
                        rd_q <= fb_q[idx_q[0]*8 +: 8];
                    if (op_q == CMD_CTL_RD || idx_q == bal_bytes - 4'(1))
                        st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < B_TAPS; i++)
                tap_q[i] <= '0;
            fb_q <= '0;
            epg_q <= '0;
            elt_q <= '0;
            gx_q <= '0;
            lat_q <= '0;
            dir_q <= '0;
            conv_q <= 1'b0;
            test_q <= '0;
            loop_q <= 1'b0;
            adapt_q <= 1'b0;
            tap_sel_q <= '0;
        end else begin
            if (wr_ok) begin
                case (op_q)
                    CMD_CTL_WR: lat_q <= cmd.wr_data[NUM_LINES-1:0];
                    CMD_DIR_WR: dir_q <= cmd.wr_data[NUM_LINES-1:0];
                    CMD_SET_IMP:
                        conv_q <= (cmd.wr_data[4:0] == IMP_LOOPBACK);
                    CMD_LOOP:   loop_q <= cmd.wr_data[0];
                    CMD_ADAPT:  adapt_q <= cmd.wr_data[0];
                    CMD_TEST:   test_q <= cmd.wr_data[3:0];
                    CMD_ELT_WR: elt_q[7:0] <= cmd.wr_data;
                    CMD_EPG_WR: epg_q[idx_q[0]*8 +: 8] <= cmd.wr_data;
                    CMD_BAL_WR:
                        if (idx_q < 4'(B_TAPS/2)) begin
                            tap_q[2*idx_q]   <= cmd.wr_data[3:0];
                            tap_q[2*idx_q+1] <= cmd.wr_data[7:4];
                        end else
                            fb_q[idx_q[0]*8 +: 8] <= cmd.wr_data;
                    default: gx_q[7:0] <= gx_q[7:0];
                endcase
            end else if (adapt_step) begin
                // only the selected tap moves; feedback and the other taps hold
                tap_q[tap_sel_q] <= tap_next;
                tap_sel_q <= tap_sel_q + 3'(1);
            end
        end
    end

    // three-stage sync on control line pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ls1_q <= '0;
            ls2_q <= '0;
            ls3_q <= '0;
            lin_q <= '0;
        end else begin
            ls1_q <= line_in;
            ls2_q <= ls1_q;
            ls3_q <= ls2_q;
            for (int i = 0; i < NUM_LINES; i++)
                if (ls2_q[i] == ls3_q[i])
                    lin_q[i] <= dir_q[i] ? lat_q[i] : ls3_q[i];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chop_cnt_q <= '0;
            chop_q <= 1'b1;
        end else if (chan_active == '0) begin
            chop_cnt_q <= '0;
            chop_q <= 1'b1;
        end else if (chop_cnt_q == $bits(chop_cnt_q)'(CHOP_HALF - 1)) begin
            chop_cnt_q <= '0;
            chop_q <= ~chop_q;
        end else
            chop_cnt_q <= chop_cnt_q + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pcm_q <= '0;
            gxc_q <= '0;
        end else begin
            pcm_q <= loop_q ? pcm_receive_input : '0;
            gxc_q <= COEF_W'(ONE_FIXED) + gx_val;
        end
    end

    assign pcm_transmit_output = pcm_q;
    assign chopper_clock    = chop_q;
    assign line_out         = lat_q;
    assign line_oe          = dir_q;
    assign conv_loopback    = conv_q;
    assign analog_out_drive = 1'b1;
    assign analog_loopback  = test_q[TEST_ALOOP];
    assign hpf_bypass       = test_q[TEST_HPF_BYP];
    assign rx_cut           = test_q[TEST_RX_CUT];
    assign tx_cut           = test_q[TEST_TX_CUT];
    assign adapt_running    = adapt_q;
    assign tx_gain_coef     = gxc_q;
    assign cmd.rd_valid     = rv_q;
    assign cmd.rd_data      = rd_q;
    assign cmd.busy         = (st_q != ST_IDLE);
endmodule // csd_filter_ctrl
`default_nettype wire

// File: rtl/csd_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module csd_host_ctrl
    import csd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       req_valid,
    input  wire logic [7:0] req_code,
    input  wire logic [7:0] req_data,
    input  wire logic       req_has_data,
    output logic            req_ready,
    output logic            resp_valid,
    output logic [7:0]      resp_data,
    codec_cmd_if.host       cmd
);
    typedef enum {H_IDLE, H_CMD, H_DATA, H_WAIT} host_state_t;
    host_state_t st_q;
    logic [7:0] code_q, data_q;
    logic       has_q, cv_q, wv_q, rv_q;
    logic [7:0] rd_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= H_IDLE;
            code_q <= '0;
            data_q <= '0;
            has_q <= 1'b0;
            cv_q <= 1'b0;
            wv_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= '0;
        end else begin
            cv_q <= 1'b0;
            wv_q <= 1'b0;
            rv_q <= cmd.rd_valid;
            if (cmd.rd_valid)
                rd_q <= cmd.rd_data;
            case (st_q)
                H_IDLE: if (req_valid && !cmd.busy) begin
                    code_q <= req_code;
                    data_q <= req_data;
                    has_q  <= req_has_data;
                    cv_q   <= 1'b1;
                    st_q   <= H_CMD;
                end else if (req_valid && req_has_data) begin
                    // next byte of a multi-byte write still open
                    data_q <= req_data;
                    wv_q   <= 1'b1;
                    st_q   <= H_WAIT;
                end
                H_CMD: st_q <= has_q ? H_DATA : H_WAIT;
                H_DATA: begin
                    wv_q <= 1'b1;   // seed or settings byte
                    st_q <= H_WAIT;
                end
                H_WAIT: if (!wv_q)
                    st_q <= H_IDLE;
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign req_ready     = (st_q == H_IDLE) && (!cmd.busy || req_has_data);
    assign resp_valid    = rv_q;
    assign resp_data     = rd_q;
    assign cmd.cmd_valid = cv_q;
    assign cmd.cmd_code  = code_q;
    assign cmd.wr_valid  = wv_q;
    assign cmd.wr_data   = data_q;
endmodule // csd_host_ctrl
`default_nettype wire

// File: testbench/csd_cmd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module csd_cmd_properties
    import csd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic       wr_valid,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    input  wire logic       busy
);
    logic       taken;
    logic [7:0] last_q;
    logic [3:0] rd_cnt_q;
    logic [4:0] stall_q;
    assign taken = cmd_valid && !busy;
    // remembers the last accepted opcode and counts read bytes since
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_q   <= 8'h00;
            rd_cnt_q <= 4'h0;
        end else if (taken) begin
            last_q   <= cmd_code;
            rd_cnt_q <= 4'h0;
        end else if (rd_valid) begin
            rd_cnt_q <= rd_cnt_q + 4'h1;
        end
    end
    // counts busy cycles in which no byte moves
    always_ff @(posedge clk) begin
        if (sys_rst || !busy || wr_valid || rd_valid)
            stall_q <= 5'h00;
        else if (stall_q != 5'h1F)
            stall_q <= stall_q + 5'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_BUSY_ON_TAKE: assert property (taken |=> busy)
        else $error("busy not raised after command");
    AST_CTL_RD_ANSWER: assert property (
        taken && cmd_code == CMD_CTL_RD |-> ##[1:4] rd_valid)
        else $error("line state read not answered");
    AST_BAL_RD_ANSWER: assert property (
        taken && cmd_code == CMD_BAL_RD |-> ##[1:4] rd_valid)
        else $error("balance read not answered");
    AST_RD_ONLY_AFTER_READ: assert property (rd_valid |->
        (last_q == CMD_CTL_RD && rd_cnt_q == 4'h0) ||
        (last_q == CMD_BAL_RD && rd_cnt_q < 4'h6))
        else $error("read byte outside a read command");
    AST_BAL_RD_SIX: assert property (
        taken && cmd_code == CMD_BAL_RD |-> ##[6:12] rd_cnt_q == 4'h6)
        else $error("balance read byte count wrong");
    AST_ADAPT_BYTE: assert property (
        taken && cmd_code == CMD_ADAPT |-> ##[1:2] wr_valid)
        else $error("adapt command without its data byte");
    AST_NO_CMD_WHILE_BUSY: assert property (busy |-> !cmd_valid)
        else $error("command issued while busy");
    AST_BUSY_BOUNDED: assert property (busy |-> stall_q < 5'h10)
        else $error("busy stuck high");
    AST_WR_IN_CMD: assert property (wr_valid |-> busy)
        else $error("data byte outside a command");
endmodule // csd_cmd_properties
`default_nettype wire

// File: testbench/csd_filter_coefficient_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module csd_filter_coefficient_control_tb_top
    import csd_pkg::*;
;
    logic clk, sys_rst, req_valid, req_has_data, req_ready, resp_valid;
    logic [7:0] req_code, req_data, resp_data, pcm_in, pcm_out, d, dir;
    logic [1:0] chan_active;
    logic signed [COEF_W-1:0] tx_level, rx_level, err_level, tx_gain_coef;
    logic [4:0] line_in, line_out, line_oe, exp5;
    logic chop, conv_lb, aout, alb, hpf, rxc, txc, adapt;
    logic [7:0] resp_q[$];
    logic [7:0] exp_b [6];
    int miscompares, checks_done, seed, i, cnt;
    codec_cmd_if cmd_bus();
    csd_host_ctrl u_csd_host_ctrl (.clk(clk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_code(req_code), .req_data(req_data),
        .req_has_data(req_has_data), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_data(resp_data), .cmd(cmd_bus));
    csd_filter_ctrl u_csd_filter_ctrl (.clk(clk), .sys_rst(sys_rst),
        .cmd(cmd_bus), .chan_active(chan_active),
        .pcm_receive_input(pcm_in), .tx_level(tx_level),
        .rx_level(rx_level), .err_level(err_level), .line_in(line_in),
        .pcm_transmit_output(pcm_out), .chopper_clock(chop),
        .line_out(line_out), .line_oe(line_oe), .conv_loopback(conv_lb),
        .analog_out_drive(aout), .analog_loopback(alb), .hpf_bypass(hpf),
        .rx_cut(rxc), .tx_cut(txc), .adapt_running(adapt),
        .tx_gain_coef(tx_gain_coef));
    csd_cmd_properties u_csd_cmd_properties (.clk(clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_bus.cmd_valid), .cmd_code(cmd_bus.cmd_code),
        .wr_valid(cmd_bus.wr_valid), .wr_data(cmd_bus.wr_data),
        .rd_valid(cmd_bus.rd_valid), .rd_data(cmd_bus.rd_data),
        .busy(cmd_bus.busy));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (resp_valid === 1'b1)
            resp_q.push_back(resp_data);
    end
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // holds the request until ready is seen, then waits for idle again
    task automatic send(input logic [7:0] code, input logic [7:0] data,
                        input logic has);
        int n;
        req_valid <= 1'b1;
        req_code <= code;
        req_data <= data;
        req_has_data <= has;
        n = 0;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            miscompares++;
        repeat (3) @(posedge clk);
    endtask
    // reads the balance set back and holds it against the model bytes
    task automatic read_bal();
        resp_q.delete();
        send(CMD_BAL_RD, 8'h00, 1'b0);
        check("balance count", 16'(resp_q.size()), 16'h6);
        foreach (resp_q[k])
            check("balance data", resp_q[k], 16'(exp_b[k]));
    endtask
    initial begin
        seed = 98915;
        miscompares = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_code = 8'h00;
        req_data = 8'h00;
        req_has_data = 1'b0;
        chan_active = 2'h0;
        pcm_in = 8'h00;
        line_in = 5'h00;
        tx_level = '0;
        rx_level = '0;
        err_level = '0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check("chopper idle", 16'(chop), 16'h1);
        // four zero terms decode to 4.0, plus one
        check("tx gain", 16'(tx_gain_coef), 16'(5 << FRAC_BITS));
        resp_q.delete();
        send(CMD_BAL_RD, 8'h00, 1'b0);
        check("balance bytes", 16'(resp_q.size()), 16'h6);
        foreach (resp_q[k]) check("balance byte", resp_q[k], 16'h0);
        for (i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            dir = 8'($random(seed));
            line_in <= 5'($random(seed));
            tx_level <= 16'($random(seed));
            rx_level <= 16'($random(seed));
            err_level <= 16'($random(seed));
            send(CMD_CTL_WR, d, 1'b1);
            send(CMD_DIR_WR, dir, 1'b1);
            check("line_out", 16'(line_out), 16'(d[4:0]));
            check("line_oe", 16'(line_oe), 16'(dir[4:0]));
            exp5 = (dir[4:0] & d[4:0]) | (~dir[4:0] & line_in);
            resp_q.delete();
            send(CMD_CTL_RD, 8'h00, 1'b0);
            check("line reads", 16'(resp_q.size()), 16'h1);
            check("line state", 16'(resp_q[0]), 16'(exp5));
        end
        for (i = 0; i < 16; i++) begin
            send(CMD_TEST, 8'(i), 1'b1);
            check("test bits", 16'({alb, txc, rxc, hpf}), 16'(i));
        end
        send(CMD_SET_IMP, 8'(IMP_LOOPBACK), 1'b1);
        check("conv loop", 16'({conv_lb, aout}), 16'h3);
        send(CMD_SET_IMP, 8'h05, 1'b1);
        check("conv loop off", 16'(conv_lb), 16'h0);
        send(CMD_LOOP, 8'h01, 1'b1);
        pcm_in <= 8'($random(seed));
        repeat (3) @(posedge clk);
        check("slot loop", 16'(pcm_out), 16'(pcm_in));
        // model of the balance set: four tap bytes, then feedback lo, hi
        for (i = 0; i < 6; i++) begin
            exp_b[i] = 8'($random(seed));
            send((i == 0) ? CMD_BAL_WR : 8'h00, exp_b[i], 1'b1);
        end
        read_bal();
        // threshold and echo gain both decode to 32 in Q4.12
        send(CMD_ELT_WR, 8'h77, 1'b1);
        send(CMD_EPG_WR, 8'h77, 1'b1);
        send(8'h00, 8'h77, 1'b1);
        rx_level <= 16'h4000;
        tx_level <= 16'h0000;
        err_level <= 16'h0010;
        send(CMD_ADAPT, 8'h01, 1'b1);
        check("adapt on", 16'(adapt), 16'h1);
        repeat (20) @(posedge clk);
        read_bal();
        tx_level <= 16'h1000;
        err_level <= 16'h0100;
        repeat (20) @(posedge clk);
        read_bal();
        tx_level <= 16'h0000;
        repeat (100) @(posedge clk);
        send(CMD_ADAPT, 8'h00, 1'b1);
        check("adapt off", 16'(adapt), 16'h0);
        // each step lifts one tap's shift by one, holding at 7, signed by the error
        for (i = 0; i < 4; i++)
            exp_b[i] = 8'hFF;
        read_bal();
        repeat (20) @(posedge clk);
        read_bal();
        chan_active <= 2'h2;
        cnt = 0;
        while (chop === 1'b1 && cnt < 200) begin
            @(posedge clk);
            cnt++;
        end
        cnt = 0;
        while (chop === 1'b0 && cnt < 200) begin
            @(posedge clk);
            cnt++;
        end
        check("chop half", 16'(cnt), 16'(CHOP_HALF));
        chan_active <= 2'h0;
        repeat (2 * CHOP_HALF + 4) @(posedge clk);
        check("chopper parked", 16'(chop), 16'h1);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule // csd_filter_coefficient_control_tb_top
`default_nettype wire
